// *** hdl/thermometer_scratchpad_alarm.sv ***
// Scratchpad, identification word, resolution and alarm logic of the sensor.
`timescale 1ns/1ps
`include "thermo_scratch_map.svh"

module thermometer_scratchpad_alarm
  import thermo_scratch_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // Arbitrary value.
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB, // Arbitrary.
  parameter logic [7:0] EE_HIGH_INIT = 8'h7D,
  parameter logic [7:0] EE_LOW_INIT = 8'hC9
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic busReset,
  input wire logic romCmdDone,
  input wire logic romCmdOverdrive,
  input wire scratch_wr_s scratchWr,
  input wire logic [2:0] rdAddr,
  input wire logic copyStrobe,
  input wire conv_result_s convIn,
  input wire logic [5:0] romBitIdx,
  input wire logic chainOn,
  input wire logic chainDone,
  input wire logic secondPortPinIn,
  input wire logic vddSenseIn,
  output logic bootDone,
  output logic ctrlAccess,
  output logic overdriveMode,
  output logic [7:0] rdData,
  output rom_id_s romId,
  output logic romBit,
  output logic alarmFlag,
  output logic condSearchRespond,
  output logic condReadRespond,
  output logic firstPortPinOut,
  output logic firstPortPinOe,
  output logic localPower,
  output logic [1:0] resolution
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // One step of the reflected CRC shifter; feedback taps x5, x4 and x0.
  function automatic logic [7:0] crcStep(input logic [7:0] crc,
                                         input logic bitIn);
    crcStep = {1'b0, crc[7:1]}
              ^ ((crc[0] ^ bitIn) ? `CRC_POLY_REFL : 8'h00);
  endfunction

  // Mask that clears the result bits that are undefined at a given resolution.
  function automatic logic [15:0] lowMask(input logic [1:0] res);
    case (res)
      2'b00: lowMask = 16'hFFF8;
      2'b01: lowMask = 16'hFFFC;
      2'b10: lowMask = 16'hFFFE;
      default: lowMask = 16'hFFFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] enSync_ff, vddSync_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enSync_ff <= 2'b11;
      vddSync_ff <= 2'b00;
    end
    else
    begin
      enSync_ff <= {enSync_ff[0], secondPortPinIn};
      vddSync_ff <= {vddSync_ff[0], vddSenseIn};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequence: scratchpad load, then identification CRC.

  boot_state_e state_ff, nxt_state;
  logic [6:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] crc_ff, nxt_crc;
  logic [7:0] romCrc_ff, nxt_romCrc;
  logic loadNow, shiftBit;
  logic [55:0] idData;

  assign idData = {SERIAL_NUMBER, FAMILY_CODE};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_crc = crc_ff;
    nxt_romCrc = romCrc_ff;
    loadNow = 1'b0;
    shiftBit = 1'b0;
    case (state_ff)
      ST_LOAD:
      begin
        loadNow = 1'b1;
        nxt_crc = `CRC_SEED;
        nxt_bitCnt = 7'h00;
        nxt_state = ST_CRC;
      end
      ST_CRC:
      begin
        shiftBit = (bitCnt_ff < `ID_DATA_BITS) ? idData[bitCnt_ff[5:0]]
                   : romCrc_ff[bitCnt_ff[2:0]];
        nxt_crc = crcStep(crc_ff, shiftBit);
        if (bitCnt_ff == `ID_DATA_BITS - 7'h01)
          nxt_romCrc = crcStep(crc_ff, shiftBit);
        nxt_bitCnt = bitCnt_ff + 7'h01;
        if (bitCnt_ff == `ID_LAST_BIT)
          nxt_state = ST_RUN;
      end
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ST_LOAD;
      bitCnt_ff <= 7'h00;
      crc_ff <= `CRC_SEED;
      romCrc_ff <= `CRC_SEED;
    end
    else
    begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      crc_ff <= nxt_crc;
      romCrc_ff <= nxt_romCrc;
    end
  end

  assign bootDone = (state_ff == ST_RUN);
  assign romId = {romCrc_ff, idData};
  always_comb romBit = romId[romBitIdx];

  ////////////////////////////////////////////////////////////////////////////
  // Command gating and speed.

  logic access_ff, nxt_access, od_ff, nxt_od;

  always_comb
  begin
    nxt_access = access_ff;
    nxt_od = od_ff;
    if (busReset)
      nxt_access = 1'b0;
    else if (romCmdDone && bootDone)
    begin
      nxt_access = 1'b1;
      if (romCmdOverdrive)
        nxt_od = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      access_ff <= 1'b0;
      od_ff <= 1'b0;
    end
    else
    begin
      access_ff <= nxt_access;
      od_ff <= nxt_od;
    end
  end

  assign ctrlAccess = access_ff;
  assign overdriveMode = od_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Scratchpad, EEPROM backup and alarm.

  logic [15:0] temp_ff, nxt_temp, convFmt;
  logic [7:0] thr_hi_ff, nxt_thr_hi;
  logic [7:0] thr_lo_ff, nxt_thr_lo;
  logic [1:0] res_ff, nxt_res;
  logic [7:0] ee_hi_ff, nxt_ee_hi;
  logic [7:0] ee_lo_ff, nxt_ee_lo;
  logic [7:0] ee_cfg_ff, nxt_ee_cfg;
  logic alarm_ff, nxt_alarm, wrOk;
  logic [7:0] rd_ff, nxt_rd, cfgByte;
  logic signed [7:0] intDeg;

  assign cfgByte = (`CFG_FIXED_VAL & ~`CFG_WRITE_MASK)
                   | {1'b0, res_ff, 5'h00};
  assign wrOk = scratchWr.en && access_ff && bootDone;
  assign convFmt = {{4{convIn.raw[11]}}, convIn.raw} & lowMask(res_ff);
  assign intDeg = convIn.raw[11:4];

  always_comb
  begin
    nxt_temp = temp_ff;
    nxt_thr_hi = thr_hi_ff;
    nxt_thr_lo = thr_lo_ff;
    nxt_res = res_ff;
    nxt_ee_hi = ee_hi_ff;
    nxt_ee_lo = ee_lo_ff;
    nxt_ee_cfg = ee_cfg_ff;
    nxt_alarm = alarm_ff;
    if (loadNow)
    begin
      nxt_thr_hi = ee_hi_ff;
      nxt_thr_lo = ee_lo_ff;
      nxt_res = ee_cfg_ff[`CFG_RES_HI:`CFG_RES_LO];
    end
    else if (wrOk)
    begin
      case (scratchWr.addr)
        `OFS_HIGH_THR: nxt_thr_hi = scratchWr.data;
        `OFS_LOW_THR: nxt_thr_lo = scratchWr.data;
        `OFS_CONFIG: nxt_res = scratchWr.data[`CFG_RES_HI:`CFG_RES_LO];
        default: nxt_res = res_ff;
      endcase
    end
    if (copyStrobe && access_ff && bootDone)
    begin
      nxt_ee_hi = thr_hi_ff;
      nxt_ee_lo = thr_lo_ff;
      nxt_ee_cfg = cfgByte;
    end
    if (convIn.done && bootDone)
    begin
      nxt_temp = convFmt;
      nxt_alarm = intDeg >= $signed(thr_hi_ff)
                  || intDeg <= $signed(thr_lo_ff);
    end
    case (rdAddr)
      `OFS_TEMP_LOW: nxt_rd = temp_ff[7:0];
      `OFS_TEMP_HIGH: nxt_rd = temp_ff[15:8];
      `OFS_HIGH_THR: nxt_rd = thr_hi_ff;
      `OFS_LOW_THR: nxt_rd = thr_lo_ff;
      `OFS_CONFIG: nxt_rd = cfgByte;
      `OFS_RSVD_FIVE: nxt_rd = `RST_RSVD_FIVE;
      `OFS_RSVD_SIX: nxt_rd = `RST_RSVD_SIX;
      default: nxt_rd = `RST_RSVD_SEVEN;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      temp_ff <= {`RST_TEMP_HIGH, `RST_TEMP_LOW};
      thr_hi_ff <= 8'h00;
      thr_lo_ff <= 8'h00;
      res_ff <= 2'b11;
      ee_hi_ff <= EE_HIGH_INIT;
      ee_lo_ff <= EE_LOW_INIT;
      ee_cfg_ff <= `CFG_FACTORY;
      alarm_ff <= 1'b0;
      rd_ff <= 8'h00;
    end
    else
    begin
      temp_ff <= nxt_temp;
      thr_hi_ff <= nxt_thr_hi;
      thr_lo_ff <= nxt_thr_lo;
      res_ff <= nxt_res;
      ee_hi_ff <= nxt_ee_hi;
      ee_lo_ff <= nxt_ee_lo;
      ee_cfg_ff <= nxt_ee_cfg;
      alarm_ff <= nxt_alarm;
      rd_ff <= nxt_rd;
    end
  end

  assign rdData = rd_ff;
  assign alarmFlag = alarm_ff;
  assign condSearchRespond = alarm_ff;
  assign resolution = res_ff;
  assign localPower = vddSync_ff[1];
  assign condReadRespond = chainOn && !enSync_ff[1];
  assign firstPortPinOut = 1'b0;
  assign firstPortPinOe = chainDone;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_crc_residue_zero: assert property (
    (state_ff == ST_CRC && bitCnt_ff == `ID_LAST_BIT) |=> crc_ff == 8'h00)
    else $error("CRC residue not zero after check bits.");
  a_boot_length: assert property (
    state_ff == ST_LOAD |-> ##65 bootDone)
    else $error("Boot sequence length wrong.");
  a_load_thresh: assert property (
    state_ff == ST_LOAD |=> thr_hi_ff == $past(ee_hi_ff)
    && thr_lo_ff == $past(ee_lo_ff))
    else $error("Thresholds not loaded from backup.");
  a_temp_ro: assert property (
    !convIn.done |=> temp_ff == $past(temp_ff))
    else $error("Temperature changed without conversion.");
  a_rsvd_read: assert property (
    rdAddr == `OFS_RSVD_SIX |=> rdData == `RST_RSVD_SIX)
    else $error("Reserved byte six reads wrong.");
  a_cfg_fixed: assert property (
    rdAddr == `OFS_CONFIG |=> rdData[7] == 1'b0 && rdData[4:0] == 5'h1F)
    else $error("Fixed configuration bits wrong.");
  a_access_gate: assert property (
    !access_ff && !romCmdDone |=> !access_ff)
    else $error("Control access without ROM command.");
  a_od_sticky: assert property (
    od_ff |=> od_ff)
    else $error("Overdrive mode dropped.");
  a_alarm_set: assert property (
    convIn.done && bootDone && intDeg >= $signed(thr_hi_ff)
    |=> alarmFlag ##1 condSearchRespond)
    else $error("Alarm not raised at high threshold.");
  a_alarm_clear: assert property (
    $fell(alarm_ff) |-> $past(convIn.done)
    && $past(intDeg) > $past($signed(thr_lo_ff))
    && $past(intDeg) < $past($signed(thr_hi_ff)))
    else $error("Alarm cleared outside thresholds.");
  a_low_bits: assert property (
    convIn.done && bootDone && res_ff == 2'b00 |=> temp_ff[2:0] == 3'h0)
    else $error("Undefined low bits not masked.");
  a_copy_backup: assert property (
    copyStrobe && access_ff && bootDone |=> ee_hi_ff == $past(thr_hi_ff)
    && ee_lo_ff == $past(thr_lo_ff) && ee_cfg_ff == $past(cfgByte))
    else $error("Backup storage not updated by copy.");

  c_boot_done: cover property ($rose(bootDone));
  c_alarm_cycle: cover property ($rose(alarm_ff) ##[1:200] $fell(alarm_ff));
  c_overdrive: cover property ($rose(od_ff));
  c_copy: cover property (copyStrobe && access_ff);

endmodule

// *** hdl/thermo_scratch_map.svh ***
// Offsets, reset values, field positions and counts of the thermometer block.
`ifndef THERMO_SCRATCH_MAP_SVH
`define THERMO_SCRATCH_MAP_SVH

`define OFS_TEMP_LOW 3'h0
`define OFS_TEMP_HIGH 3'h1
`define OFS_HIGH_THR 3'h2
`define OFS_LOW_THR 3'h3
`define OFS_CONFIG 3'h4
`define OFS_RSVD_FIVE 3'h5
`define OFS_RSVD_SIX 3'h6
`define OFS_RSVD_SEVEN 3'h7

`define RST_TEMP_LOW 8'h50
`define RST_TEMP_HIGH 8'h05
`define RST_RSVD_FIVE 8'hFF
`define RST_RSVD_SIX 8'h0C
`define RST_RSVD_SEVEN 8'h10

`define CFG_RES_HI 6
`define CFG_RES_LO 5
`define CFG_FIXED_VAL 8'h1F
`define CFG_WRITE_MASK 8'h60
`define CFG_FACTORY 8'h7F

`define CRC_SEED 8'h00
`define CRC_POLY_REFL 8'h8C
`define ID_DATA_BITS 7'h38
`define ID_ALL_BITS 7'h40
`define ID_LAST_BIT 7'h3F

`endif

// *** hdl/thermo_scratch_pkg.sv ***
// Types shared by the thermometer scratchpad block.
package thermo_scratch_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_CRC = 2'b01,
    ST_RUN = 2'b10
  } boot_state_e;

  typedef struct packed {
    logic en;
    logic [2:0] addr;
    logic [7:0] data;
  } scratch_wr_s;

  typedef struct packed {
    logic done;
    logic [11:0] raw;
  } conv_result_s;

  typedef struct packed {
    logic [7:0] crc;
    logic [47:0] serial;
    logic [7:0] family;
  } rom_id_s;

endpackage

// *** bench/thermo_master_model.sv ***
// Bus master model that issues ROM commands and bus resets to the block.
`timescale 1ns/1ps

module thermo_master_model
  import thermo_scratch_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cmdReq,
  input wire logic cmdOd,
  input wire logic slow,
  input wire logic rstReq,
  output logic romCmdDone,
  output logic romCmdOverdrive,
  output logic busReset
);

  logic [2:0] waitCnt_ff;
  logic odHeld_ff;

  // The overdrive flag toggles outside a completion so it is only trusted together with romCmdDone.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitCnt_ff <= 3'h0;
      odHeld_ff <= 1'b0;
      romCmdDone <= 1'b0;
      romCmdOverdrive <= 1'b0;
      busReset <= 1'b0;
    end
    else
    begin
      busReset <= rstReq;
      romCmdDone <= 1'b0;
      romCmdOverdrive <= ~romCmdOverdrive;
      if (cmdReq)
      begin
        waitCnt_ff <= slow ? 3'h4 : 3'h1;
        odHeld_ff <= cmdOd;
      end
      else if (waitCnt_ff != 3'h0)
      begin
        waitCnt_ff <= waitCnt_ff - 3'h1;
        if (waitCnt_ff == 3'h1)
        begin
          romCmdDone <= 1'b1;
          romCmdOverdrive <= odHeld_ff;
        end
      end
    end
  end

endmodule

// *** bench/thermometer_scratchpad_alarm_tb.sv ***
// Self-checking testbench of the thermometer scratchpad and alarm block.
`timescale 1ns/1ps

module thermometer_scratchpad_alarm_tb
  import thermo_scratch_pkg::*;
;

  localparam logic [7:0] FAM = 8'h3C; // Arbitrary value.
  localparam logic [47:0] SER = 48'hA1B2C3D4E5F6;
  logic core_clk, arst_n, busReset, romCmdDone, romCmdOverdrive;
  scratch_wr_s scratchWr;
  conv_result_s convIn;
  logic [2:0] rdAddr;
  logic [5:0] romBitIdx;
  logic copyStrobe, chainOn, chainDone, secondPortPinIn, vddSenseIn;
  logic bootDone, ctrlAccess, overdriveMode, romBit, alarmFlag;
  logic condSearchRespond, condReadRespond, firstPortPinOut, firstPortPinOe;
  logic localPower;
  logic [1:0] resolution;
  logic [7:0] rdData, crc, d;
  logic [63:0] idExp;
  rom_id_s romId;
  logic cmdReq, cmdOd, slow, rstReq, rdVld, seenVld;
  logic [7:0] expQ[$];
  logic [7:0] img[8];
  logic [11:0] raw;
  int n_fail, checks_done, seed, i, k;

  thermometer_scratchpad_alarm #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER),
    .EE_HIGH_INIT(8'h7D), .EE_LOW_INIT(8'hC9))
  thermometer_scratchpad_alarm_inst (
    .core_clk(core_clk), .arst_n(arst_n), .busReset(busReset),
    .romCmdDone(romCmdDone), .romCmdOverdrive(romCmdOverdrive),
    .scratchWr(scratchWr), .rdAddr(rdAddr), .copyStrobe(copyStrobe),
    .convIn(convIn), .romBitIdx(romBitIdx), .chainOn(chainOn),
    .chainDone(chainDone), .secondPortPinIn(secondPortPinIn),
    .vddSenseIn(vddSenseIn), .bootDone(bootDone), .ctrlAccess(ctrlAccess),
    .overdriveMode(overdriveMode), .rdData(rdData), .romId(romId),
    .romBit(romBit), .alarmFlag(alarmFlag),
    .condSearchRespond(condSearchRespond), .condReadRespond(condReadRespond),
    .firstPortPinOut(firstPortPinOut), .firstPortPinOe(firstPortPinOe),
    .localPower(localPower), .resolution(resolution));

  thermo_master_model thermo_master_model_inst (.core_clk(core_clk),
    .arst_n(arst_n), .cmdReq(cmdReq), .cmdOd(cmdOd), .slow(slow),
    .rstReq(rstReq), .romCmdDone(romCmdDone),
    .romCmdOverdrive(romCmdOverdrive), .busReset(busReset));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [2:0] a);
    @(negedge core_clk);
    rdAddr = a;
    rdVld = 1'b1;
    expQ.push_back(img[a]);
    @(negedge core_clk);
    rdVld = 1'b0;
  endtask

  task automatic rdAll();
    for (k = 0; k < 8; k++)
      rd(k[2:0]);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge core_clk);
    scratchWr = '{en: 1'b1, addr: a, data: v};
    @(negedge core_clk);
    scratchWr.en = 1'b0;
  endtask

  task automatic conv(input logic [11:0] r);
    @(negedge core_clk);
    convIn = '{done: 1'b1, raw: r};
    @(negedge core_clk);
    convIn.done = 1'b0;
  endtask

  task automatic romCmd(input logic od, input logic s);
    @(negedge core_clk);
    cmdReq = 1'b1;
    cmdOd = od;
    slow = s;
    @(negedge core_clk);
    cmdReq = 1'b0;
    for (k = 0; k < 20 && romCmdDone !== 1'b1; k++)
      @(negedge core_clk);
    if (k == 20)
      stop_test_bound();
    @(negedge core_clk);
  endtask

  task automatic stop_test_bound();
    n_fail++;
    $display("wrong value at %0t: wait bound used up", $time);
    stop_test();
  endtask

  // Each read note is compared on the falling edge one clock cycle after its address was presented.
  always @(posedge core_clk)
    seenVld <= rdVld;
  always @(negedge core_clk)
    if (seenVld)
    begin
      checks_done++;
      if (rdData !== expQ[0])
      begin
        n_fail++;
        $display("wrong value at %0t: read %h expected %h", $time, rdData,
          expQ[0]);
      end
      void'(expQ.pop_front());
    end

  initial
  begin
    repeat (100000) @(posedge core_clk);
    stop_test_bound();
  end

  initial
  begin
    seed = 32'hE1692AF7;
    {arst_n, scratchWr, convIn, rdAddr, romBitIdx, copyStrobe} = '0;
    {chainOn, chainDone, cmdReq, cmdOd, slow, rstReq, rdVld} = '0;
    secondPortPinIn = 1'b1;
    vddSenseIn = 1'b0;
    img = '{8'h50, 8'h05, 8'h7D, 8'hC9, 8'h7F, 8'hFF, 8'h0C, 8'h10};
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    for (i = 0; i < 100 && bootDone !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 100)
      stop_test_bound();
    rdAll();
    chk(resolution, 2'b11);
    chk({condReadRespond, firstPortPinOe, localPower}, 3'b000);
    crc = 8'h00;
    idExp = {8'h00, SER, FAM};
    for (i = 0; i < 64; i++)
    begin
      @(negedge core_clk);
      romBitIdx = i[5:0];
      if (i == 56)
      begin
        chk(romId.crc, crc);
        idExp[63:56] = crc;
      end
      #1 chk(romBit, idExp[i]);
      crc = (crc >> 1) ^ ((crc[0] ^ romBit) ? 8'h8C : 8'h00);
    end
    chk(crc, 8'h00);
    chk(romId, idExp);
    wr(3'h2, 8'h11);
    rd(3'h2);
    romCmd(1'b0, 1'b1);
    chk({overdriveMode, ctrlAccess}, 2'b01);
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      wr(i[2:0], d);
      if (i == 2 || i == 3)
        img[i] = d;
      if (i == 4)
        img[4] = (d & 8'h60) | 8'h1F;
    end
    rdAll();
    chk(resolution, img[4][6:5]);
    @(negedge core_clk);
    copyStrobe = 1'b1;
    @(negedge core_clk);
    copyStrobe = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      wr(3'h4, {1'b0, i[1:0], 5'h00});
      raw = $random(seed);
      conv(raw);
      d = 8'hFF << (3 - i);
      img[0] = raw[7:0] & d;
      img[1] = {{4{raw[11]}}, raw[11:8]};
      rd(3'h0);
      rd(3'h1);
    end
    wr(3'h2, 8'h19);
    wr(3'h3, 8'h0A);
    wr(3'h4, 8'h60);
    foreach (img[j])
      if (j > 1 && j < 5)
        img[j] = j == 2 ? 8'h19 : j == 3 ? 8'h0A : 8'h7F;
    rd(3'h2);
    for (i = 0; i < 6; i++)
    begin
      raw = i == 0 ? 12'h191 : i == 1 ? 12'h0B0 : i == 2 ? 12'h0A0 :
        i == 3 ? 12'h18F : i == 4 ? 12'hF5E : 12'h100;
      conv(raw);
      chk({alarmFlag, condSearchRespond}, {2{~i[0]}});
    end
    romCmd(1'b1, 1'b0);
    chk(overdriveMode, 1'b1);
    @(negedge core_clk);
    rstReq = 1'b1;
    @(negedge core_clk);
    rstReq = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(ctrlAccess, 1'b0);
    chk(overdriveMode, 1'b1);
    wr(3'h3, 8'h44);
    rd(3'h3);
    chainOn = 1'b1;
    secondPortPinIn = 1'b0;
    vddSenseIn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({condReadRespond, localPower}, 2'b11);
    secondPortPinIn = 1'b1;
    chainDone = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({condReadRespond, firstPortPinOe, firstPortPinOut}, 3'b010);
    repeat (4) @(negedge core_clk);
    stop_test();
  end

endmodule
